// ==== rtl/dsl_pkg.sv ====
// Package: constants and carrier types for the serial-load DAC front end
package dsl_pkg;
   localparam int unsigned WORD_BITS  = 16;
   localparam int unsigned CNT_BITS   = 5;
   localparam logic [15:0] ZERO_SCALE = 16'h0000;
   localparam logic [4:0]  CNT_RESET  = 5'h00;
   localparam logic [4:0]  CNT_FULL   = 5'h10;
   localparam logic [4:0]  CNT_FIRST  = 5'h01;
   // Idle levels of frame select, load strobe and clear: all high
   localparam logic [2:0]  PIN_IDLE   = 3'h7;

   // Word captured at the end of a frame, handed to the system domain
   typedef struct packed {
      logic [15:0] word;
      logic        full;
   } dsl_frame_t;

   typedef enum logic [1:0] {
      DSL_IDLE  = 2'b00,
      DSL_SHIFT = 2'b01
   } dsl_link_state_t;
endpackage

// ==== rtl/dsl_sync.sv ====
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/1ps
module dsl_sync #(
   parameter int unsigned      WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // First stage feeds only the second
   always_comb begin
      next_meta = d;
      next_q    = meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= RESET_VAL;                // Idle level of the lane, so no false edge
         q    <= RESET_VAL;
      end else begin
         meta <= next_meta;
         q    <= next_q;
      end
   end
endmodule

// ==== rtl/dsl_top.sv ====
// Serial load front end: shift register on the link clock, DAC register on SYS_CLK
// Function
// - Frame select low marks one serial word; its edges bound the word.
// - Data is sampled into the shift register on each rising link clock while frame select is low.
// - Words are sixteen bits or longer, the last sixteen kept; the shift register holds sixteen.
// - Load strobe falling copies the serial register into the DAC register.
// - Clear acts on its falling edge, independent of the link clock; the code holds both registers at zero for as long as it is low.
// - While clear is low, load strobe pulses are ignored.
// - Clear zeroes both the serial register and the DAC register.
// - Bits arrive most significant first.
// - Frame end after sixteen bits with strobe low loads the DAC register.
// - Frame end with strobe high keeps the word in the serial register only.
// - Link activity while frame select is high changes nothing.
`timescale 1ns/1ps
module dsl_top (
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   input  wire logic        LINK_CLK,
   input  wire logic        FRAME_SEL_N,
   input  wire logic        SER_DATA,
   input  wire logic        DAC_LOAD_STROBE_N,
   input  wire logic        ASYNC_CLEAR_N,
   output logic [15:0]      DAC_CODE,
   output logic [15:0]      SERIAL_WORD,
   output logic             WORD_VALID
);
   // ------------------------------------------------------------
   // Link domain: shifter
   // ------------------------------------------------------------
   logic [15:0] shift;
   logic [15:0] next_shift;
   logic [4:0]  bit_cnt;
   logic [4:0]  next_bit_cnt;
   logic        frame_open;
   logic        next_frame_open;

   // Clear is not carried into this domain: the link clock may be parked,
   // so a synchronised clear could linger and eat the first bits of a frame.
   // The system side holds both registers at zero while clear is low.

   // Shift MSB first while selected; the count restarts on the first edge
   // of each frame and saturates at sixteen, so a short frame never latches
   always_comb begin
      next_shift      = shift;
      next_bit_cnt    = bit_cnt;
      next_frame_open = frame_open;
      if (!FRAME_SEL_N) begin
         next_shift      = {shift[14:0], SER_DATA};
         next_frame_open = 1'b1;
         if (!frame_open) begin
            next_bit_cnt = dsl_pkg::CNT_FIRST;
         end else if (bit_cnt != dsl_pkg::CNT_FULL) begin
            next_bit_cnt = bit_cnt + 5'h01;
         end
      end
   end

   always_ff @(posedge LINK_CLK or negedge NRST) begin
      if (!NRST) begin
         shift   <= dsl_pkg::ZERO_SCALE;
         bit_cnt <= dsl_pkg::CNT_RESET;
      end else begin
         shift   <= next_shift;
         bit_cnt <= next_bit_cnt;
      end
   end

   // Frame marker: set by the first link edge of a frame, dropped at once
   // when frame select rises; the count is kept for the word handover,
   // which is judged in SYS_CLK because the link clock may stop after a frame
   always_ff @(posedge LINK_CLK or posedge FRAME_SEL_N) begin
      if (FRAME_SEL_N) begin
         frame_open <= 1'b0;
      end else begin
         frame_open <= next_frame_open;
      end
   end

   // ------------------------------------------------------------
   // System domain: synchronise pins
   // ------------------------------------------------------------
   // Pins idle high, so the synchroniser starts high as well: a stage
   // that came out of reset low would show a false edge on each pin
   logic [2:0] pins_s;
   dsl_sync #(.WIDTH(3), .RESET_VAL(dsl_pkg::PIN_IDLE)) u_pin_sync (
      .clk   (SYS_CLK),
      .rst_n (NRST),
      .d     ({FRAME_SEL_N, DAC_LOAD_STROBE_N, ASYNC_CLEAR_N}),
      .q     (pins_s)
   );
   logic sel_n_s;
   logic dac_load_strobe_n_n_s;
   logic clr_n_s;
   assign sel_n_s  = pins_s[2];
   assign dac_load_strobe_n_n_s = pins_s[1];
   assign clr_n_s  = pins_s[0];

   // ------------------------------------------------------------
   // System domain: serial and DAC registers
   // ------------------------------------------------------------
   // Shift data is stable once frame select is high (link edges then change nothing),
   // so sampling it after the synchronised rising edge is a safe word handover.
   logic [15:0] shift_s;
   logic [4:0]  cnt_s;
   dsl_sync #(.WIDTH(21)) u_word_sync (
      .clk   (SYS_CLK),
      .rst_n (NRST),
      .d     ({shift, bit_cnt}),
      .q     ({shift_s, cnt_s})
   );

   logic            sel_n_d;
   logic            dac_load_strobe_n_n_d;
   logic            clr_n_d;
   logic            next_sel_n_d;
   logic            next_dac_load_strobe_n_n_d;
   logic            next_clr_n_d;
   logic [15:0]     ser_reg;
   logic [15:0]     next_ser_reg;
   logic [15:0]     dac_reg;
   logic [15:0]     next_dac_reg;
   logic            valid;
   logic            next_valid;
   logic            frame_end;
   logic            dac_load_strobe_n_fall;
   logic            clr_fall;
   logic [2:0]      settle;
   logic [2:0]      next_settle;
   dsl_pkg::dsl_frame_t frame;

   assign frame_end = sel_n_s && !sel_n_d;
   assign dac_load_strobe_n_fall = !dac_load_strobe_n_n_s && dac_load_strobe_n_n_d;
   assign clr_fall  = !clr_n_s && clr_n_d;
   assign frame.word = shift_s;
   assign frame.full = (cnt_s == dsl_pkg::CNT_FULL);

   // Wait a few cycles after frame end so the word synchroniser settles
   always_comb begin
      next_sel_n_d  = sel_n_s;
      next_dac_load_strobe_n_n_d = dac_load_strobe_n_n_s;
      next_clr_n_d  = clr_n_s;
      next_ser_reg  = ser_reg;
      next_dac_reg  = dac_reg;
      next_valid    = valid;
      next_settle   = {settle[1:0], frame_end};
      if (clr_fall || !clr_n_s) begin
         next_ser_reg = dsl_pkg::ZERO_SCALE;
         next_dac_reg = dsl_pkg::ZERO_SCALE;
         next_valid   = 1'b0;
         next_settle  = 3'h0;
      end else begin
         if (settle[2] && frame.full) begin
            next_ser_reg = frame.word;
            next_valid   = 1'b1;
            if (!dac_load_strobe_n_n_s) begin
               next_dac_reg = frame.word;
            end
         end else if (dac_load_strobe_n_fall) begin
            next_dac_reg = ser_reg;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         sel_n_d  <= 1'b1;
         dac_load_strobe_n_n_d <= 1'b1;
         clr_n_d  <= 1'b1;
         ser_reg  <= dsl_pkg::ZERO_SCALE;
         dac_reg  <= dsl_pkg::ZERO_SCALE;
         valid    <= 1'b0;
         settle   <= 3'h0;
      end else begin
         sel_n_d  <= next_sel_n_d;
         dac_load_strobe_n_n_d <= next_dac_load_strobe_n_n_d;
         clr_n_d  <= next_clr_n_d;
         ser_reg  <= next_ser_reg;
         dac_reg  <= next_dac_reg;
         valid    <= next_valid;
         settle   <= next_settle;
      end
   end

   assign DAC_CODE    = dac_reg;
   assign SERIAL_WORD = ser_reg;
   assign WORD_VALID  = valid;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   clear_zeroes_dac_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      !clr_n_s |=> (dac_reg == 16'h0000 && ser_reg == 16'h0000))
      else $error("clear did not zero registers");
   clear_blocks_load_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (!clr_n_s && dac_load_strobe_n_fall) |=> $stable(dac_reg) || dac_reg == 16'h0000)
      else $error("load accepted during clear");
   strobe_loads_dac_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (dac_load_strobe_n_fall && clr_n_s && !settle[2]) |=> dac_reg == $past(ser_reg))
      else $error("strobe did not load DAC");
   frame_load_dac_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (settle[2] && frame.full && !dac_load_strobe_n_n_s && clr_n_s) |=> dac_reg == ser_reg)
      else $error("frame end did not load DAC");
   frame_keep_dac_a: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (settle[2] && dac_load_strobe_n_n_s && clr_n_s && !dac_load_strobe_n_fall) |=> $stable(dac_reg))
      else $error("DAC changed with strobe high");
   // Link-side checks: sampled on the link clock, which only runs in bursts
   idle_shift_hold_a: assert property (@(posedge LINK_CLK) disable iff (!NRST)
      FRAME_SEL_N |=> $stable(shift))
      else $error("shift moved outside frame");
   msb_first_a: assert property (@(posedge LINK_CLK) disable iff (!NRST)
      !FRAME_SEL_N |=> shift[0] == $past(SER_DATA) && shift[15:1] == $past(shift[14:0]))
      else $error("shift order wrong");
   count_bound_a: assert property (@(posedge LINK_CLK) disable iff (!NRST)
      bit_cnt <= dsl_pkg::CNT_FULL)
      else $error("bit count overran");
   count_restart_a: assert property (@(posedge LINK_CLK) disable iff (!NRST)
      (!FRAME_SEL_N && !frame_open) |=> bit_cnt == dsl_pkg::CNT_FIRST)
      else $error("bit count did not restart");
endmodule

// ==== bench/dsl_host.sv ====
// Host serial controller model that frames words onto the link
`timescale 1ns/1ps
module dsl_host (
   output logic LINK_CLK,
   output logic FRAME_SEL_N,
   output logic SER_DATA
);
   // Idle link: frame closed, clock parked low
   initial begin
      LINK_CLK = 1'b0;
      FRAME_SEL_N = 1'b1;
      SER_DATA = 1'b0;
   end

   // One frame, MSB first; the clock stands still before and after the frame
   task automatic send(input logic [15:0] word, input int nbits);
      FRAME_SEL_N = 1'b0;
      #6;
      for (int i = 15; i > 15 - nbits; i--) begin
         SER_DATA = word[i];
         #6 LINK_CLK = 1'b1;
         #6 LINK_CLK = 1'b0;
      end
      #6 FRAME_SEL_N = 1'b1;
      SER_DATA = ~SER_DATA;                      // Released line never shows the last bit
      #48;                                       // Gap above the 40 ns minimum
   endtask

   // Clock and data wiggle with the frame closed
   task automatic noise(input int n);
      for (int i = 0; i < n; i++) begin
         SER_DATA = ~SER_DATA;
         #6 LINK_CLK = 1'b1;
         #6 LINK_CLK = 1'b0;
      end
   endtask
endmodule

// ==== bench/test_dsl_top.sv ====
// Self-checking bench for the serial load front end
`timescale 1ns/1ps
module test_dsl_top;
   logic        sys_clk;
   logic        nrst;
   logic        link_clk;
   logic        frame_sel_n;
   logic        ser_data;
   logic        load_n;
   logic        clear_n;
   logic [15:0] dac_code;
   logic [15:0] serial_word;
   logic        word_valid;
   int          bad_count = 0;
   int          tests_run = 0;
   int          cycles = 0;

   dsl_host i_host (.LINK_CLK(link_clk), .FRAME_SEL_N(frame_sel_n), .SER_DATA(ser_data));

   dsl_top i_dut (.SYS_CLK(sys_clk), .NRST(nrst), .LINK_CLK(link_clk), .FRAME_SEL_N(frame_sel_n),
      .SER_DATA(ser_data), .DAC_LOAD_STROBE_N(load_n), .ASYNC_CLEAR_N(clear_n),
      .DAC_CODE(dac_code), .SERIAL_WORD(serial_word), .WORD_VALID(word_valid));

   // ----------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Ceiling is about ten times the expected run of some four hundred cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         $display("mismatch at %0t: run did not finish", $time);
         end_sim();
      end
   end

   task automatic end_sim();
      if (bad_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Valid flag rides in bit 16 so one compare covers both
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Covers the 6-7 cycle crossing with margin
   task automatic settle();
      repeat (12) @(negedge sys_clk);
   endtask

   task automatic strobe();
      @(negedge sys_clk) load_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      load_n = 1'b1;
      settle();
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_preload();
      i_host.send(16'hA5C3, 16);
      settle();
      chk({word_valid, serial_word}, {1'b1, 16'hA5C3});
      chk({1'b0, dac_code}, {1'b0, dsl_pkg::ZERO_SCALE});
      strobe();
      chk({1'b0, dac_code}, {1'b0, 16'hA5C3});
      i_host.noise(16);
      settle();
      chk({word_valid, serial_word}, {1'b1, 16'hA5C3});
   endtask

   task automatic t_frame_load();
      @(negedge sys_clk) load_n = 1'b0;
      i_host.send(16'h8001, 16);
      settle();
      chk({1'b0, dac_code}, {1'b0, 16'h8001});
      @(negedge sys_clk) load_n = 1'b1;
   endtask

   // Clear with the link parked, then a strobe while it is held
   task automatic t_clear();
      @(negedge sys_clk) clear_n = 1'b0;
      settle();
      chk({word_valid, serial_word}, {1'b0, dsl_pkg::ZERO_SCALE});
      chk({1'b0, dac_code}, {1'b0, dsl_pkg::ZERO_SCALE});
      i_host.send(16'h1234, 16);
      strobe();
      chk({1'b0, dac_code}, {1'b0, dsl_pkg::ZERO_SCALE});
      @(negedge sys_clk) clear_n = 1'b1;
      settle();
      chk({word_valid, serial_word}, {1'b0, dsl_pkg::ZERO_SCALE});
   endtask

   // Fifteen bits after a clear must not make a word
   task automatic t_short();
      i_host.send(16'hFFFF, 15);
      settle();
      chk({word_valid, serial_word}, {1'b0, dsl_pkg::ZERO_SCALE});
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      load_n = 1'b1;
      clear_n = 1'b1;
      i_host.noise(1);
      repeat (8) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk({word_valid, serial_word}, {1'b0, dsl_pkg::ZERO_SCALE});
      t_preload();
      t_frame_load();
      t_clear();
      t_short();
      end_sim();
   end
endmodule
